// *** verilog/au_pkg.sv ***
// Package of the arithmetic unit: special-function addresses, control fields,
// reset values, timing counts and the enumerations shared by the unit's modules.
// Assumes one core clock of 250 MHz and a core that issues byte-wide accesses.
package au_pkg;

  // ==========================================================================
  // Special-function addresses
  // ==========================================================================
  localparam logic [7:0] AU_ADDR_ARITH_CONTROL = 8'hEF;
  localparam logic [7:0] AU_ADDR_OPERAND_BYTE_0 = 8'hE9;
  localparam int AU_OPERAND_BYTES = 6;

  // ==========================================================================
  // Control register fields and reset value
  // ==========================================================================
  localparam int AU_CTL_ERR_BIT = 7;
  localparam int AU_CTL_OVF_BIT = 6;
  localparam int AU_CTL_DIR_BIT = 5;
  localparam int AU_CTL_CNT_MSB = 4;
  localparam logic [7:0] AU_CTL_RESET = 8'h00;
  localparam logic [7:0] AU_CTL_WR_MASK = 8'h3F;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int AU_CLK_PERIOD_PS = 4000;
  localparam int AU_MCYC_TIME_PS = 48000;
  localparam int AU_MCYC_CLKS = AU_MCYC_TIME_PS / AU_CLK_PERIOD_PS;
  localparam logic [3:0] AU_MCYC_LAST = 4'(AU_MCYC_CLKS - 1);
  localparam logic [2:0] AU_SHORT_MCYC = 3'h4;
  localparam logic [2:0] AU_LONG_MCYC = 3'h6;
  localparam logic [4:0] AU_SHIFT_PER_MCYC = 5'h06;
  localparam logic [4:0] AU_NORM_MAX = 5'h1F;

  // ==========================================================================
  // Enumerations
  // ==========================================================================
  typedef enum logic [7:0] {
    AU_SEQ_IDLE = 8'h01,
    AU_SEQ_B0 = 8'h02,
    AU_SEQ_D1 = 8'h04,
    AU_SEQ_D2 = 8'h08,
    AU_SEQ_D3 = 8'h10,
    AU_SEQ_D4 = 8'h20,
    AU_SEQ_M4 = 8'h40,
    AU_SEQ_M1 = 8'h80
  } au_seq_t;

  typedef enum logic [3:0] {
    AU_OP_NONE = 4'h1,
    AU_OP_DIV = 4'h2,
    AU_OP_MUL = 4'h4,
    AU_OP_SHIFT = 4'h8
  } au_op_t;

endpackage : au_pkg

// *** verilog/au_calc_if.sv ***
// Interface between the arithmetic unit's control and its calculation core.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ps
interface au_calc_if;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic [15:0] mcand;
  logic [15:0] mplier;
  logic [31:0] sh_in;
  logic [4:0] sh_left;
  logic sh_right;
  logic sh_norm;
  logic [31:0] quot;
  logic [15:0] rem;
  logic div_zero;
  logic [31:0] prod;
  logic [31:0] sh_out;
  logic [4:0] sh_step;

  modport ctrl (
    output dividend, divisor, mcand, mplier, sh_in, sh_left, sh_right, sh_norm,
    input quot, rem, div_zero, prod, sh_out, sh_step
  );
  modport calc (
    input dividend, divisor, mcand, mplier, sh_in, sh_left, sh_right, sh_norm,
    output quot, rem, div_zero, prod, sh_out, sh_step
  );
endinterface : au_calc_if

// *** verilog/au_calc.sv ***
// Calculation core of the arithmetic unit: divide, multiply and one shift step.
// Assumes its inputs stay stable while the control side waits for a result.
`timescale 1ns/1ps
module au_calc
  import au_pkg::*;
(
  au_calc_if.calc cif
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [4:0] au_min5(input logic [4:0] a, input logic [4:0] b);
    return (a < b) ? a : b;
  endfunction : au_min5

  logic [5:0] lead_zeros;
  logic found;
  logic [4:0] step;

  // ==========================================================================
  // Integer divide and multiply
  // ==========================================================================
  always_comb begin
    cif.div_zero = (cif.divisor == 16'h0000);
    if (cif.div_zero) begin
      cif.quot = 32'hFFFFFFFF;
      cif.rem = cif.dividend[15:0];
    end else begin
      cif.quot = cif.dividend / {16'h0000, cif.divisor};
      cif.rem = 16'(cif.dividend % {16'h0000, cif.divisor});
    end
    cif.prod = {16'h0000, cif.mcand} * {16'h0000, cif.mplier};
  end

  // ==========================================================================
  // Shift step of at most six places
  // ==========================================================================
  always_comb begin
    lead_zeros = 6'h00;
    found = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!found) begin
        if (cif.sh_in[i]) begin
          found = 1'b1;
        end else begin
          lead_zeros = lead_zeros + 6'h01;
        end
      end
    end
    step = au_min5(AU_SHIFT_PER_MCYC, cif.sh_left);
    if (cif.sh_norm && (lead_zeros < 6'h20)) begin
      step = au_min5(step, lead_zeros[4:0]);
    end
    cif.sh_step = step;
    if (cif.sh_right) begin
      cif.sh_out = cif.sh_in >> step;
    end else begin
      cif.sh_out = cif.sh_in << step;
    end
  end

endmodule : au_calc

// *** verilog/au_top.sv ***
// Top of the arithmetic unit: special-function register slave, operand bytes,
// write-order decoder and machine-cycle timing of divide, multiply and shift.
// Assumes a core that issues one-cycle read and write strobes with an address.
`timescale 1ns/1ps
module au_top
  import au_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  output logic busy
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [5:0][7:0] ob;
    logic [7:0] ctl;
    au_seq_t seq;
    au_op_t op;
    logic [2:0] left;
    logic [3:0] mc;
    logic [31:0] sh;
    logic [4:0] sh_rem;
    logic [4:0] sh_cnt;
    logic norm;
    logic [7:0] rdata;
    logic rvalid;
  } au_state_t;

  au_state_t q;
  au_state_t d;

  au_calc_if cif ();

  logic tick;
  logic is_busy;
  logic hit_ctl;
  logic hit_op;
  logic [2:0] idx;
  logic wr_ok;
  logic hit_any;

  // ==========================================================================
  // Address decode
  // ==========================================================================
  function automatic logic au_is_operand(input logic [7:0] a);
    return (a >= AU_ADDR_OPERAND_BYTE_0) &&
           (a < AU_ADDR_OPERAND_BYTE_0 + 8'(AU_OPERAND_BYTES));
  endfunction : au_is_operand

  function automatic logic [2:0] au_index(input logic [7:0] a);
    logic [7:0] off;
    off = a - AU_ADDR_OPERAND_BYTE_0;
    return off[2:0];
  endfunction : au_index

  // ==========================================================================
  // Decode and arithmetic helpers
  // ==========================================================================
  // True while an operation is running.
  function automatic logic au_busy_op(input au_op_t op);
    return (op != AU_OP_NONE);
  endfunction : au_busy_op

  // Length of a division in machine cycles, from the dividend's upper half.
  function automatic logic [2:0] au_div_len(input logic [15:0] hi);
    return (hi == 16'h0000) ? AU_SHORT_MCYC : AU_LONG_MCYC;
  endfunction : au_div_len

  // Control byte after a write: only the writable fields change.
  function automatic logic [7:0] au_ctl_merge(input logic [7:0] old, input logic [7:0] wd);
    return (old & ~AU_CTL_WR_MASK) | (wd & AU_CTL_WR_MASK);
  endfunction : au_ctl_merge

  // Places left to shift: a zero count asks for a full normalize.
  function automatic logic [4:0] au_shift_span(input logic [7:0] wd);
    return (wd[AU_CTL_CNT_MSB:0] == 5'h00) ? AU_NORM_MAX : wd[AU_CTL_CNT_MSB:0];
  endfunction : au_shift_span

  // Next step of the write-order decoder after one operand byte write.
  function automatic au_seq_t au_seq_next(input au_seq_t s, input logic [2:0] i);
    au_seq_t n;
    n = AU_SEQ_IDLE;
    if (i == 3'h0) begin
      n = AU_SEQ_B0;
    end else begin
      case (s)
        AU_SEQ_B0: begin
          if (i == 3'h1) begin
            n = AU_SEQ_D1;
          end else if (i == 3'h4) begin
            n = AU_SEQ_M4;
          end
        end
        AU_SEQ_D1: begin
          if (i == 3'h2) begin
            n = AU_SEQ_D2;
          end
        end
        AU_SEQ_D2: begin
          if (i == 3'h3) begin
            n = AU_SEQ_D3;
          end
        end
        AU_SEQ_D3: begin
          if (i == 3'h4) begin
            n = AU_SEQ_D4;
          end
        end
        AU_SEQ_M4: begin
          if (i == 3'h1) begin
            n = AU_SEQ_M1;
          end
        end
        // A divide or multiply start ends the decode.
        AU_SEQ_D4: begin
          n = AU_SEQ_IDLE;
        end
        AU_SEQ_M1: begin
          n = AU_SEQ_IDLE;
        end
        default: begin
          n = AU_SEQ_IDLE;
        end
      endcase
    end
    return n;
  endfunction : au_seq_next

  assign hit_ctl = (sfr_addr == AU_ADDR_ARITH_CONTROL);
  assign hit_op = au_is_operand(sfr_addr);
  assign idx = au_index(sfr_addr);
  assign hit_any = hit_ctl || hit_op;

  // ==========================================================================
  // Calculation core
  // ==========================================================================
  assign cif.dividend = q.ob[3:0];
  assign cif.divisor = q.ob[5:4];
  assign cif.mcand = {q.ob[1], q.ob[0]};
  assign cif.mplier = {q.ob[5], q.ob[4]};
  assign cif.sh_in = q.sh;
  assign cif.sh_left = q.sh_rem;
  assign cif.sh_right = q.ctl[AU_CTL_DIR_BIT] & ~q.norm;
  assign cif.sh_norm = q.norm;

  au_calc u_calc (
    .cif(cif)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    tick = (q.mc == AU_MCYC_LAST);
    is_busy = au_busy_op(q.op);
    wr_ok = sfr_wr && !is_busy;

    // Machine-cycle divider.
    if (tick) begin
      d.mc = 4'h0;
    end else begin
      d.mc = q.mc + 4'h1;
    end

    // Computation phase.
    if (is_busy && tick) begin
      if (q.op == AU_OP_SHIFT) begin
        d.sh = cif.sh_out;
        d.sh_rem = q.sh_rem - cif.sh_step;
        d.sh_cnt = q.sh_cnt + cif.sh_step;
      end
      if (q.left <= 3'h1) begin
        d.left = 3'h0;
        d.op = AU_OP_NONE;
        case (q.op)
          AU_OP_DIV: begin
            d.ob = {cif.rem, cif.quot};
            d.ctl[AU_CTL_OVF_BIT] = cif.div_zero;
          end
          AU_OP_MUL: begin
            d.ob[3:0] = cif.prod;
            d.ctl[AU_CTL_OVF_BIT] = |cif.prod[31:16];
          end
          AU_OP_SHIFT: begin
            d.ob[3:0] = cif.sh_out;
            if (q.norm) begin
              d.ctl[AU_CTL_CNT_MSB:0] = q.sh_cnt + cif.sh_step;
            end
          end
          default: begin
            d.op = AU_OP_NONE;
          end
        endcase
      end else begin
        d.left = q.left - 3'h1;
      end
    end

    // Read access: answer one cycle later, stale while busy.
    if (sfr_rd && hit_any) begin
      d.rvalid = 1'b1;
      if (hit_ctl) begin
        d.rdata = q.ctl;
        d.ctl[AU_CTL_ERR_BIT] = 1'b0;
      end else begin
        d.rdata = q.ob[idx];
      end
      if (is_busy) begin
        d.ctl[AU_CTL_ERR_BIT] = 1'b1;
      end
    end

    // Write during computation is dropped and flagged.
    if (sfr_wr && is_busy && hit_any) begin
      d.ctl[AU_CTL_ERR_BIT] = 1'b1;
    end

    // Control write: starts shift or normalize.
    if (wr_ok && hit_ctl) begin
      d.ctl = au_ctl_merge(q.ctl, sfr_wdata);
      d.ctl[AU_CTL_OVF_BIT] = 1'b0;
      d.op = AU_OP_SHIFT;
      d.left = AU_LONG_MCYC;
      d.sh = q.ob[3:0];
      d.norm = (sfr_wdata[AU_CTL_CNT_MSB:0] == 5'h00);
      d.sh_rem = au_shift_span(sfr_wdata);
      d.sh_cnt = 5'h00;
      d.seq = AU_SEQ_IDLE;
    end

    // Operand write, sequence decode and start of divide or multiply.
    if (wr_ok && hit_op) begin
      d.ob[idx] = sfr_wdata;
      d.seq = au_seq_next(q.seq, idx);
      case (q.seq)
        AU_SEQ_D4: begin
          if (idx == 3'h5) begin
            d.op = AU_OP_DIV;
            d.ctl[AU_CTL_OVF_BIT] = 1'b0;
            d.left = au_div_len({q.ob[3], q.ob[2]});
          end
        end
        AU_SEQ_M1: begin
          if (idx == 3'h5) begin
            d.op = AU_OP_MUL;
            d.ctl[AU_CTL_OVF_BIT] = 1'b0;
            d.left = AU_SHORT_MCYC;
          end
        end
        default: begin
          d.op = q.op;
        end
      endcase
    end

    // Synchronous reset.
    if (srst) begin
      d = '0;
      d.ctl = AU_CTL_RESET;
      d.seq = AU_SEQ_IDLE;
      d.op = AU_OP_NONE;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    q <= d;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign sfr_rdata = q.rdata;
  assign sfr_rvalid = q.rvalid;
  assign busy = au_busy_op(q.op);

endmodule : au_top

// *** test/au_top_checker.sv ***
// Checker of the arithmetic unit's special-function bus and busy timing.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
module au_top_checker
  import au_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid,
  input wire logic busy
);
  // ====================
  // Helper logic
  // ====================
  logic hit;
  logic [7:0] bcnt_q;
  assign hit = (sfr_addr >= AU_ADDR_OPERAND_BYTE_0) && (sfr_addr <= AU_ADDR_ARITH_CONTROL);
  always_ff @(posedge core_clk) begin
    bcnt_q <= (srst || !busy) ? 8'h00 : bcnt_q + 8'h01;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ====================
  // Assertions
  // ====================
  a_read_answer: assert property (sfr_rd && hit |=> sfr_rvalid)
    else $error("Read was not answered.");
  a_stray_rvalid: assert property (sfr_rvalid |-> $past(sfr_rd && hit))
    else $error("Read answer without a read.");
  a_rdata_holds: assert property ($changed(sfr_rdata) |-> sfr_rvalid)
    else $error("Read data moved without an answer.");
  a_ctl_starts: assert property (sfr_wr && sfr_addr == AU_ADDR_ARITH_CONTROL && !busy |=> busy)
    else $error("Control write did not start a shift.");
  a_start_cause: assert property ($rose(busy) |-> $past(sfr_wr && !busy &&
    (sfr_addr == AU_ADDR_ARITH_CONTROL || sfr_addr == AU_ADDR_OPERAND_BYTE_0 + 8'h05)))
    else $error("Busy rose without a starting write.");
  a_busy_max: assert property (busy |-> bcnt_q <= 8'h47)
    else $error("Operation ran past six machine cycles.");
  a_busy_min: assert property ($fell(busy) |-> $past(bcnt_q) >= 8'h24)
    else $error("Operation ended too early.");
  a_start_steady: assert property ($rose(busy) |-> busy [*8])
    else $error("Busy dropped right after start.");
  c_start: cover property ($rose(busy));
  c_busy_write: cover property (busy && sfr_wr);
  c_unmapped: cover property (sfr_rd && !hit);
endmodule : au_top_checker

bind au_top au_top_checker u_au_top_checker (.core_clk(core_clk), .srst(srst),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .busy(busy));

// *** test/au_core_model.sv ***
// Core-side model: issues one-cycle read and write strobes on the bus.
// Assumes the unit answers a read exactly one cycle after the strobe.
`timescale 1ns/1ps
module au_core_model (
  input wire logic core_clk,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid
);
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end
  // One access at a time, never overlapping another.
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
    sfr_wdata = ~d;
  endtask : wr_byte
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    ok = sfr_rvalid;
    d = sfr_rdata;
  endtask : rd_byte
endmodule : au_core_model

// *** test/mul_div_shift_unit_tb_top.sv ***
// Testbench of the arithmetic unit against an integer model of its results.
// Assumes the core model drives the bus at falling edges.
`timescale 1ns/1ps
module mul_div_shift_unit_tb_top
  import au_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic sfr_wr, sfr_rd, sfr_rvalid, busy;
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h798A959C;
  localparam logic [7:0] B0 = AU_ADDR_OPERAND_BYTE_0;
  localparam logic [7:0] CTL = AU_ADDR_ARITH_CONTROL;
  always #2 core_clk = ~core_clk;
  au_top u_au_top (.core_clk(core_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
    .busy(busy));
  au_core_model u_au_core_model (.core_clk(core_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid));
  // ====================
  // Helpers
  // ====================
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    logic ok;
    u_au_core_model.rd_byte(a, d, ok);
    chk({31'h0, ok}, 32'h1, "read answer");
  endtask : rd8
  task automatic rd32(output logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      rd8(B0 + 8'(i), v[8*i+:8]);
    end
  endtask : rd32
  task automatic wr32(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      u_au_core_model.wr_byte(B0 + 8'(i), v[8*i+:8]);
    end
  endtask : wr32
  // Waits for the end of an operation of nmc machine cycles; used core clock cycles already past.
  task automatic run(input int nmc, input int used);
    int n;
    n = used;
    while (busy === 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 200) begin
      chk(0, 1, "busy timeout");
      test_done();
    end
    chk(n >= (nmc - 1) * AU_MCYC_CLKS - 1 && n <= nmc * AU_MCYC_CLKS, 1, "duration");
  endtask : run
  task automatic div_load(input logic [31:0] dd, input logic [15:0] ds);
    wr32(dd);
    u_au_core_model.wr_byte(B0 + 8'h04, ds[7:0]);
    u_au_core_model.wr_byte(B0 + 8'h05, ds[15:8]);
    chk({31'h0, busy}, 32'h1, "division start");
  endtask : div_load
  task automatic div_check(input logic [31:0] dd, input logic [15:0] ds);
    logic [31:0] q;
    logic [7:0] lo, hi;
    rd32(q);
    rd8(B0 + 8'h04, lo);
    rd8(B0 + 8'h05, hi);
    chk(q, (ds == 0) ? 32'hFFFFFFFF : dd / ds, "quotient");
    chk({hi, lo}, (ds == 0) ? dd[15:0] : 16'(dd % ds), "remainder");
    if (ds == 0) begin
      rd8(CTL, lo);
      chk(lo[AU_CTL_OVF_BIT], 1, "divide by zero flag");
    end
  endtask : div_check
  // ====================
  // Main sequence
  // ====================
  initial begin
    repeat (100000) @(posedge core_clk);
    chk(0, 1, "run timeout");
    test_done();
  end
  initial begin
    logic [31:0] a, b, e;
    logic [7:0] c;
    logic ok;
    int k;
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd8(B0 + 8'(i), c);
      chk(c, 0, "reset value");
    end
    u_au_core_model.rd_byte(8'hE8, c, ok);
    chk(ok, 0, "unmapped read");
    u_au_core_model.rd_byte(8'hF0, c, ok);
    chk(ok, 0, "unmapped read");
    for (int i = 0; i < 6; i++) begin
      a = xs();
      b = (i == 2) ? 32'h0 : xs();
      if (i == 1) a[31:16] = 16'h0;
      div_load(a, b[15:0]);
      run((a[31:16] != 0) ? 6 : 4, 0);
      div_check(a, b[15:0]);
    end
    for (int i = 0; i < 4; i++) begin
      a = xs();
      b = xs();
      u_au_core_model.wr_byte(B0, a[7:0]);
      u_au_core_model.wr_byte(B0 + 8'h04, b[7:0]);
      u_au_core_model.wr_byte(B0 + 8'h01, a[15:8]);
      u_au_core_model.wr_byte(B0 + 8'h05, b[15:8]);
      run(4, 0);
      rd32(e);
      b = 32'(a[15:0]) * 32'(b[15:0]);
      chk(e, b, "product");
      rd8(CTL, c);
      chk(c[AU_CTL_OVF_BIT], b[31:16] != 16'h0000, "product overflow");
    end
    for (int i = 0; i < 6; i++) begin
      k = (xs() % 31) + 1;
      a = xs();
      c = (i % 3 == 0) ? 8'(k) : (i % 3 == 1) ? 8'h20 | 8'(k) : 8'h00;
      if (i % 3 == 2) a = (a | 32'h80000000) >> k;
      e = (i % 3 == 0) ? a << k : (i % 3 == 1) ? a >> k : a;
      if (i % 3 == 2) for (k = 0; !e[31]; k++) e = e << 1;
      wr32(a);
      u_au_core_model.wr_byte(CTL, c);
      chk({31'h0, busy}, 32'h1, "shift start");
      run(6, 0);
      rd32(a);
      chk(a, e, "shift result");
      rd8(CTL, c);
      chk(c[5:0], {i % 3 == 1, 5'(k)}, "shift control");
    end
    a = xs() | 32'h00010000;
    div_load(a, 16'h0103);
    rd8(B0, c);
    chk(c, a[7:0], "read while busy");
    u_au_core_model.wr_byte(B0, 8'h5A);
    run(6, 4);
    div_check(a, 16'h0103);
    rd8(CTL, c);
    chk(c[AU_CTL_ERR_BIT], 1, "error flag set");
    rd8(CTL, c);
    chk(c[AU_CTL_ERR_BIT], 0, "error flag cleared");
    u_au_core_model.wr_byte(B0, 8'h11);
    u_au_core_model.wr_byte(B0 + 8'h04, 8'h22);
    u_au_core_model.wr_byte(B0 + 8'h05, 8'h33);
    repeat (3) @(negedge core_clk);
    chk({31'h0, busy}, 32'h0, "broken order");
    test_done();
  end
endmodule : mul_div_shift_unit_tb_top
